// >>> rtl/rstsc_pkg.sv
// constants for the reset status and control block
package rstsc_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned POR_HOLD_MS = 64;
	localparam int unsigned POR_HOLD_CYC = (CLK_HZ / 1000) * POR_HOLD_MS;
	localparam int unsigned EXTERNAL_RESET_PIN_MIN_US = 10;
	localparam int unsigned EXTERNAL_RESET_PIN_MIN_CYC = (CLK_HZ / 1000000) * EXTERNAL_RESET_PIN_MIN_US;
	localparam logic [7:0] PSC_ADDR = 8'hFF;
	localparam logic [7:0] CLKCFG_ADDR = 8'hF0;
	localparam logic [7:0] PSC_RESET = 8'h10;
	localparam logic [7:0] PSC_WR_MASK = 8'h09;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam int unsigned BIT_IES = 7;
	localparam int unsigned BIT_WATCHDOG_RESET_FLAG = 5;
	localparam int unsigned BIT_POWER_ON_RESET_FLAG = 4;
	localparam int unsigned BIT_SLEEP = 3;
	localparam int unsigned BIT_STOP = 0;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [2:0] CPU_DIV_POR = 3'h3;
	localparam logic [1:0] TIMER_SEL_MIN = 2'h0;
	localparam logic CLK_INTERNAL = 1'b0;
endpackage

// >>> rtl/rstsc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module rstsc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_r <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule // rstsc_sync
`default_nettype wire

// >>> rtl/rstsc_top.sv
// reset sequencing and processor status and control register
// Notes on behaviour
// RULE_01: any reset restores every register default and disables all interrupts; a watchdog reset here keeps the CPU clock divider.
// RULE_02: after reset release the CPU fetches from address zero.
// RULE_03: after reset the clock source is internal until firmware changes it.
// RULE_04: reset returns the sleep/watchdog timer to its shortest interval.
// RULE_05: power-on reset sets the CPU clock divider to divide by eight.
// RULE_06: bit 7 is read-only and mirrors the global interrupt enable flag.
// RULE_07: watchdog reset sets bit 5; software can clear, never set it.
// RULE_08: power-on reset sets bit 4; software clears only; reset value 0x10.
// RULE_09: watchdog resets are suppressed while the power-on flag is set.
// RULE_10: writing 1 to bit 3 sleeps the CPU until an interrupt is pending.
// RULE_11: writing 1 to bit 0 halts the CPU until watchdog or power-on reset.
// RULE_12: three reset sources; power-on and watchdog causes logged separately.
// RULE_13: after power-on reset the CPU stays suspended for 64 ms.
// RULE_14: external pin high for at least 10 us causes a full power-on reset.
// RULE_15: clearing the power-on flag enables the watchdog until next power-on.
// RULE_16: reserved bits 6, 2, 1 read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module rstsc_top #(
	parameter int unsigned POR_HOLD_CYCLES = rstsc_pkg::POR_HOLD_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_external_reset_pin,
	input  wire logic        i_watchdog_reset_event,
	input  wire logic        i_global_irq_enable,
	input  wire logic        i_irq_pending,
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	output logic             o_cpu_run,
	output logic             o_cpu_reset,
	output logic             o_sleep,
	output logic             o_halted,
	output logic             o_irq_disable,
	output logic      [15:0] o_fetch_addr,
	output logic             o_clk_external,
	output logic      [2:0]  o_cpu_div_sel,
	output logic      [1:0]  o_timer_sel,
	output logic             o_watchdog_enable
);
	typedef enum logic [1:0] {ST_POR_HOLD, ST_RUN, ST_HALT} rstsc_state_t;

	logic         external_reset_pin_s;
	logic         soft_por;
	logic         wdr_take;
	logic         wr_psc;
	logic         wr_cfg;
	logic         rd_hit;
	logic         power_on_reset_flag_r;
	logic         watchdog_reset_flag_r;
	logic         sleep_r;
	logic         stop_r;
	logic         wdt_en_r;
	logic         clk_ext_r;
	logic [2:0]   div_r;
	logic [1:0]   tsel_r;
	logic [31:0]  hold_r;
	logic [31:0]  external_reset_pin_cnt_r;
	logic         any_rst;
	logic [7:0]   psc_view;
	rstsc_state_t state_r;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	rstsc_sync #(.W(1)) u_external_reset_pin_sync (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_external_reset_pin),
		.o_sync    (external_reset_pin_s)
	);

	assign wr_psc = i_wr && addr_is(i_addr, rstsc_pkg::PSC_ADDR);
	assign wr_cfg = i_wr && addr_is(i_addr, rstsc_pkg::CLKCFG_ADDR);
	assign rd_hit = addr_is(i_addr, rstsc_pkg::PSC_ADDR);

	// pin held past the minimum width triggers power-on sequence
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			external_reset_pin_cnt_r <= '0;
		else if (!external_reset_pin_s)
			external_reset_pin_cnt_r <= '0;
		else if (external_reset_pin_cnt_r < rstsc_pkg::EXTERNAL_RESET_PIN_MIN_CYC)
			external_reset_pin_cnt_r <= external_reset_pin_cnt_r + 32'd1;
	end
	assign soft_por = external_reset_pin_s && (external_reset_pin_cnt_r == rstsc_pkg::EXTERNAL_RESET_PIN_MIN_CYC - 1); // [RULE_14]

	// watchdog only counts once enabled and power-on flag clear
	assign wdr_take = i_watchdog_reset_event && wdt_en_r && !power_on_reset_flag_r; // [RULE_09] [RULE_12]
	// pin resets arrive as soft_por, so these two cover pin and watchdog; power-on comes in on i_rst_n
	assign any_rst  = soft_por || wdr_take; // [RULE_12]

	// cause flags: hardware set wins over software clear
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			power_on_reset_flag_r <= 1'b1; // [RULE_08]
		else if (soft_por)
			power_on_reset_flag_r <= 1'b1; // [RULE_08]
		else if (wr_psc && !i_wdata[rstsc_pkg::BIT_POWER_ON_RESET_FLAG])
			power_on_reset_flag_r <= 1'b0;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			watchdog_reset_flag_r <= 1'b0;
		else if (wdr_take)
			watchdog_reset_flag_r <= 1'b1; // [RULE_07]
		else if (soft_por)
			watchdog_reset_flag_r <= 1'b0;
		else if (wr_psc && !i_wdata[rstsc_pkg::BIT_WATCHDOG_RESET_FLAG])
			watchdog_reset_flag_r <= 1'b0; // [RULE_07]
	end

	// watchdog enable latches on flag clear, dropped only by power-on
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			wdt_en_r <= 1'b0;
		else if (soft_por)
			wdt_en_r <= 1'b0; // [RULE_15]
		else if (!power_on_reset_flag_r)
			wdt_en_r <= 1'b1; // [RULE_15]
	end

	// sleep and stop controls
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sleep_r <= 1'b0;
			stop_r  <= 1'b0;
		end
		else if (any_rst)
		begin
			sleep_r <= 1'b0; // [RULE_01]
			stop_r  <= 1'b0;
		end
		else
		begin
			if (wr_psc)
				sleep_r <= i_wdata[rstsc_pkg::BIT_SLEEP]; // [RULE_10]
			else if (i_irq_pending)
				sleep_r <= 1'b0; // [RULE_10]
			if (wr_psc && i_wdata[rstsc_pkg::BIT_STOP])
				stop_r <= 1'b1; // [RULE_11]
		end
	end

	// clocking configuration: [0] external, [3:1] divider, [5:4] timer
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			clk_ext_r <= rstsc_pkg::CLK_INTERNAL;
			div_r     <= rstsc_pkg::CPU_DIV_POR;
			tsel_r    <= rstsc_pkg::TIMER_SEL_MIN;
		end
		else if (any_rst)
		begin
			clk_ext_r <= rstsc_pkg::CLK_INTERNAL; // [RULE_03]
			tsel_r    <= rstsc_pkg::TIMER_SEL_MIN; // [RULE_04]
			if (soft_por)
				div_r <= rstsc_pkg::CPU_DIV_POR; // [RULE_05]
		end
		else if (wr_cfg)
		begin
			clk_ext_r <= i_wdata[0];
			div_r     <= i_wdata[3:1];
			tsel_r    <= i_wdata[5:4];
		end
	end

	// sequencer: power-on hold, run, halt
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_r <= ST_POR_HOLD;
			hold_r  <= '0;
		end
		else if (soft_por)
		begin
			state_r <= ST_POR_HOLD;
			hold_r  <= '0;
		end
		else
		begin
			unique case (state_r)
				ST_POR_HOLD:
				begin
					if (hold_r >= POR_HOLD_CYCLES - 1)
						state_r <= ST_RUN; // [RULE_13]
					else
						hold_r <= hold_r + 32'd1;
				end
				ST_RUN:
				begin
					hold_r <= '0;
					// a watchdog reset in the same cycle cancels the stop
					if (stop_r && !wdr_take)
						state_r <= ST_HALT; // [RULE_11]
				end
				ST_HALT:
				begin
					if (wdr_take)
						state_r <= ST_RUN; // [RULE_11]
				end
				default:
					state_r <= ST_POR_HOLD;
			endcase
		end
	end

	assign o_cpu_reset       = (state_r == ST_POR_HOLD) || wdr_take; // [RULE_02]
	assign o_cpu_run         = (state_r == ST_RUN) && !sleep_r && !stop_r;
	assign o_sleep           = sleep_r;
	assign o_halted          = (state_r == ST_HALT) || stop_r;
	assign o_irq_disable     = o_cpu_reset; // [RULE_01]
	assign o_fetch_addr      = rstsc_pkg::RESET_VECTOR; // [RULE_02]
	assign o_clk_external    = clk_ext_r;
	assign o_cpu_div_sel     = div_r;
	assign o_timer_sel       = tsel_r;
	assign o_watchdog_enable = wdt_en_r;

	always_comb
	begin
		psc_view = '0; // [RULE_16]
		psc_view[rstsc_pkg::BIT_IES]   = i_global_irq_enable; // [RULE_06]
		psc_view[rstsc_pkg::BIT_WATCHDOG_RESET_FLAG]  = watchdog_reset_flag_r;
		psc_view[rstsc_pkg::BIT_POWER_ON_RESET_FLAG]  = power_on_reset_flag_r;
		psc_view[rstsc_pkg::BIT_SLEEP] = sleep_r;
		psc_view[rstsc_pkg::BIT_STOP]  = stop_r;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else if (i_rd && rd_hit)
			o_rdata <= psc_view;
		else if (i_rd && addr_is(i_addr, rstsc_pkg::CLKCFG_ADDR))
			o_rdata <= {2'b00, tsel_r, div_r, clk_ext_r};
		else
			o_rdata <= rstsc_pkg::RD_UNMAPPED;
	end

	// flag, sequencing and read port checks
	a_power_on_reset_flag_set_on_por: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_08]
		soft_por |=> power_on_reset_flag_r) else $error("power-on flag not set");
	a_power_on_reset_flag_no_sw_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_08]
		(!power_on_reset_flag_r && !soft_por) |=> !power_on_reset_flag_r) else $error("power-on flag set by software");
	a_power_on_reset_flag_sw_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_08]
		(wr_psc && !i_wdata[rstsc_pkg::BIT_POWER_ON_RESET_FLAG] && !soft_por) |=> !power_on_reset_flag_r)
		else $error("power-on flag not cleared");
	a_watchdog_reset_flag_no_sw_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_07]
		(!watchdog_reset_flag_r && !wdr_take) |=> !watchdog_reset_flag_r) else $error("watchdog flag set without event");
	a_watchdog_reset_flag_set_on_wdr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_07]
		wdr_take |=> watchdog_reset_flag_r) else $error("watchdog flag not set");
	a_wdr_suppressed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_09]
		(power_on_reset_flag_r && i_watchdog_reset_event) |=> !watchdog_reset_flag_r)
		else $error("watchdog event taken while power-on flag set");
	a_power_on_reset_flag_wdt_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_09]
		power_on_reset_flag_r |-> !wdt_en_r) else $error("watchdog enabled while power-on flag set");
	a_wdt_stays_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_15]
		(wdt_en_r && !soft_por) |=> wdt_en_r) else $error("watchdog disabled");
	a_wdt_turns_on: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_15]
		(!power_on_reset_flag_r && !soft_por) |=> wdt_en_r) else $error("watchdog not enabled");
	a_ies_mirror: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_06]
		(i_rd && rd_hit) |=> o_rdata[rstsc_pkg::BIT_IES] == $past(i_global_irq_enable))
		else $error("ies bad");
	a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_16]
		$past(i_rd && rd_hit) |-> (o_rdata & 8'h46) == 8'h00) else $error("reserved bits set");
	a_div_after_por: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_05]
		soft_por |=> o_cpu_div_sel == rstsc_pkg::CPU_DIV_POR) else $error("divider wrong");
	a_div_kept_wdr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_05]
		(wdr_take && !soft_por) |=> $stable(o_cpu_div_sel)) else $error("divider moved");
	a_por_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_13]
		soft_por |=> o_cpu_reset [*8]) else $error("cpu released early");
	a_hold_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_13]
		(state_r == ST_POR_HOLD && hold_r == POR_HOLD_CYCLES - 1 && !soft_por)
		|=> state_r == ST_RUN) else $error("hold not released");
	a_sleep_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_10]
		(wr_psc && i_wdata[rstsc_pkg::BIT_SLEEP] && !any_rst) |=> sleep_r)
		else $error("sleep not entered");
	a_sleep_wake: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_10]
		(sleep_r && i_irq_pending && !wr_psc) |=> !sleep_r) else $error("no wake");
	a_stop_set: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_11]
		(wr_psc && i_wdata[rstsc_pkg::BIT_STOP] && !any_rst) |=> stop_r)
		else $error("stop not taken");
	a_stop_halts: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_11]
		(state_r == ST_RUN && stop_r && !any_rst) |=> state_r == ST_HALT)
		else $error("cpu not halted");
	a_halted_no_run: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_11]
		o_halted |-> !o_cpu_run) else $error("cpu runs while halted");
	a_halt_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_11]
		(state_r == ST_HALT && wdr_take && !soft_por) |=> !o_halted)
		else $error("halt not released");
	a_wdr_clr_ctrl: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_01]
		wdr_take |=> (!sleep_r && !stop_r)) else $error("controls not reset");
	a_clk_internal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_03]
		any_rst |=> (!o_clk_external && o_timer_sel == rstsc_pkg::TIMER_SEL_MIN))
		else $error("clock not reset");
	a_external_reset_pin_one_shot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // [RULE_14]
		soft_por |=> !soft_por) else $error("pin trigger repeated");
endmodule // rstsc_top
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the reset status and control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module testbench;
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_external_reset_pin = 1'b0;
	logic        i_watchdog_reset_event = 1'b0;
	logic        i_global_irq_enable = 1'b0;
	logic        i_irq_pending = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [7:0]  o_rdata;
	logic        o_cpu_run, o_cpu_reset, o_sleep, o_halted, o_irq_disable;
	logic [15:0] o_fetch_addr;
	logic        o_clk_external, o_watchdog_enable;
	logic [2:0]  o_cpu_div_sel;
	logic [1:0]  o_timer_sel;
	int          n_errors = 0;
	int          total_checks = 0;
	rstsc_top #(.POR_HOLD_CYCLES(20)) dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
		.i_external_reset_pin(i_external_reset_pin), .i_watchdog_reset_event(i_watchdog_reset_event),
		.i_global_irq_enable(i_global_irq_enable), .i_irq_pending(i_irq_pending), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_run(o_cpu_run),
		.o_cpu_reset(o_cpu_reset), .o_sleep(o_sleep), .o_halted(o_halted),
		.o_irq_disable(o_irq_disable), .o_fetch_addr(o_fetch_addr),
		.o_clk_external(o_clk_external), .o_cpu_div_sel(o_cpu_div_sel),
		.o_timer_sel(o_timer_sel), .o_watchdog_enable(o_watchdog_enable));
	always #20 i_sys_clk = ~i_sys_clk;
	task automatic close_out();
		if (n_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1;
		`CHK(o_rdata, e)
		cyc(1);
		`CHK(o_rdata, 8'h00)
	endtask
	task automatic wait_run();
		int k;
		k = 0;
		while (o_cpu_run !== 1'b1 && k < 400)
		begin
			cyc(1);
			k++;
		end
		if (o_cpu_run !== 1'b1)
		begin
			n_errors++;
			$display("MISMATCH t=%0t cpu never ran", $time);
			close_out();
		end
	endtask
	task automatic wd_pulse(input logic e);
		@(posedge i_sys_clk);
		i_watchdog_reset_event <= 1'b1;
		#1;
		`CHK(o_cpu_reset, e)
		@(posedge i_sys_clk);
		i_watchdog_reset_event <= 1'b0;
		cyc(2);
	endtask
	task automatic t_reset();
		cyc(3);
		`CHK(o_cpu_reset, 1'b1)
		`CHK(o_irq_disable, 1'b1)
		`CHK(o_cpu_div_sel, rstsc_pkg::CPU_DIV_POR)
		`CHK(o_timer_sel, rstsc_pkg::TIMER_SEL_MIN)
		`CHK(o_clk_external, rstsc_pkg::CLK_INTERNAL)
		`CHK(o_watchdog_enable, 1'b0)
		`CHK(o_fetch_addr, 16'h0000)
		@(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		cyc(15);
		`CHK(o_cpu_run, 1'b0)
		wait_run();
		`CHK(o_irq_disable, 1'b0)
		rd(rstsc_pkg::PSC_ADDR, rstsc_pkg::PSC_RESET);
	endtask
	task automatic t_flags();
		i_global_irq_enable <= 1'b1;
		wr(rstsc_pkg::PSC_ADDR, 8'hD6);
		rd(rstsc_pkg::PSC_ADDR, 8'h90);
		wr(rstsc_pkg::PSC_ADDR, 8'h30);
		rd(rstsc_pkg::PSC_ADDR, 8'h90);
		i_global_irq_enable <= 1'b0;
		wd_pulse(1'b0);
		`CHK(o_cpu_run, 1'b1)
		rd(rstsc_pkg::PSC_ADDR, 8'h10);
		rd(8'h55, rstsc_pkg::RD_UNMAPPED);
	endtask
	task automatic t_watchdog();
		wr(rstsc_pkg::CLKCFG_ADDR, 8'h3F);
		`CHK(o_clk_external, 1'b1)
		`CHK(o_cpu_div_sel, 3'h7)
		`CHK(o_timer_sel, 2'h3)
		wr(rstsc_pkg::PSC_ADDR, 8'h00);
		cyc(1);
		`CHK(o_watchdog_enable, 1'b1)
		rd(rstsc_pkg::PSC_ADDR, 8'h00);
		wd_pulse(1'b1);
		wait_run();
		rd(rstsc_pkg::PSC_ADDR, 8'h20);
		`CHK(o_clk_external, 1'b0)
		`CHK(o_timer_sel, rstsc_pkg::TIMER_SEL_MIN)
		`CHK(o_cpu_div_sel, 3'h7)
		`CHK(o_watchdog_enable, 1'b1)
	endtask
	task automatic t_sleep_stop();
		wr(rstsc_pkg::PSC_ADDR, 8'h08);
		`CHK(o_sleep, 1'b1)
		`CHK(o_cpu_run, 1'b0)
		i_irq_pending <= 1'b1;
		wait_run();
		`CHK(o_sleep, 1'b0)
		i_irq_pending <= 1'b0;
		wr(rstsc_pkg::PSC_ADDR, 8'h21);
		`CHK(o_halted, 1'b1)
		i_irq_pending <= 1'b1;
		cyc(4);
		`CHK(o_cpu_run, 1'b0)
		i_irq_pending <= 1'b0;
		wd_pulse(1'b1);
		wait_run();
		`CHK(o_halted, 1'b0)
		rd(rstsc_pkg::PSC_ADDR, 8'h20);
	endtask
	task automatic t_ext_pin();
		wr(rstsc_pkg::PSC_ADDR, 8'h00);
		@(posedge i_sys_clk);
		i_external_reset_pin <= 1'b1;
		cyc(200);
		i_external_reset_pin <= 1'b0;
		cyc(4);
		rd(rstsc_pkg::PSC_ADDR, 8'h00);
		i_external_reset_pin <= 1'b1;
		cyc(rstsc_pkg::EXTERNAL_RESET_PIN_MIN_CYC + 10);
		i_external_reset_pin <= 1'b0;
		`CHK(o_watchdog_enable, 1'b0)
		`CHK(o_cpu_div_sel, rstsc_pkg::CPU_DIV_POR)
		wait_run();
		rd(rstsc_pkg::PSC_ADDR, 8'h10);
	endtask
	initial
	begin
		t_reset();
		t_flags();
		t_watchdog();
		t_sleep_stop();
		t_ext_pin();
		close_out();
	end
endmodule // testbench
`default_nettype wire
